// *** verilog/mpc_multi_pin.sv ***
// Register core, deferred update and control routing of the seven multifunction pins.
`timescale 1ns/1ns
`include "mpc_map.svh"
module mpc_multi_pin
    import mpc_pkg::*;
(
    input  wire logic         clk_sys,
    input  wire logic         rst_n,
    input  wire logic         reg_wr_en,
    input  wire logic         reg_rd_en,
    input  wire logic [15:0]  reg_addr,
    input  wire logic [7:0]   reg_wdata,
    output logic [7:0]        reg_rdata,
    output logic              reg_rd_ack,
    input  wire mpc_pins_t    pin_in,
    output mpc_pins_t         pin_out,
    output mpc_pins_t         pin_oe,
    output mpc_pins_t         pin_weak,
    input  wire logic [127:0] status_src,
    input  wire logic         eeprom_active,
    input  wire logic         eeprom_pin_a_oe,
    input  wire logic         eeprom_pin_b_oe,
    output logic              straps_done,
    output logic              eeprom_load_req,
    output logic              port_is_i2c,
    output logic [6:0]        i2c_dev_addr,
    output logic              update_pulse,
    output logic              ctrl_power_down,
    output logic              ctrl_clear_watchdog,
    output logic              ctrl_sync_all,
    output logic              ctrl_clear_irq
);
    // ------------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------------
    mpc_cfg_if cfg ();

    // A control destination is the OR of every input pin routed to it, each pin
    // inverted when the low bit of its mode field is set. No AND grouping is
    // done; the result goes to the control output registers, or for the update code to the pin-update edge detect.
    function automatic logic ctrl_of(input logic [6:0]      code,
                                     input mpc_pins_t       lvl,
                                     input mpc_pins_t       oe,
                                     input logic [6:0][6:0] codes,
                                     input logic [6:0][1:0] modes);
        logic hit;
        hit = 1'b0;
        for (int i = 0; i < 7; i++) begin
            if (!oe[i] && (codes[i] == code) && (code != `MPC_CODE_IDLE)) begin
                hit = hit | (lvl[i] ^ modes[i][0]);
            end
        end
        return hit;
    endfunction : ctrl_of

    // ------------------------------------------------------------------------
    // Strap sampling
    // ------------------------------------------------------------------------
    logic       strap_done_w;
    logic       strap_load_w;
    logic       strap_i2c_w;
    logic [6:0] strap_addr_w;

    mpc_strap_latch u_strap (
        .clk_sys  (clk_sys),
        .rst_n    (rst_n),
        .pin_in   (pin_in),
        .done     (strap_done_w),
        .load_req (strap_load_w),
        .is_i2c   (strap_i2c_w),
        .i2c_addr (strap_addr_w)
    );

    // ------------------------------------------------------------------------
    // Pending registers as software sees them
    // ------------------------------------------------------------------------
    logic [6:0][7:0] func_r;
    logic [7:0]      mode_lo_r;
    logic [7:0]      mode_hi_r;
    logic [6:0]      strength_r;

    wire        wr_func_w   = reg_wr_en && (reg_addr >= `MPC_OFS_FUNC_FIRST) && (reg_addr <= `MPC_OFS_FUNC_LAST);
    wire [15:0] func_off_w  = reg_addr - `MPC_OFS_FUNC_FIRST;
    wire [2:0]  func_idx_w  = func_off_w[2:0];
    wire        wr_mode_lo_w = reg_wr_en && (reg_addr == `MPC_OFS_MODE_LO);
    wire        wr_mode_hi_w = reg_wr_en && (reg_addr == `MPC_OFS_MODE_HI);
    wire        wr_str_w    = reg_wr_en && (reg_addr == `MPC_OFS_STRENGTH);
    wire        wr_upd_w    = reg_wr_en && (reg_addr == `MPC_OFS_UPDATE) && reg_wdata[`MPC_BIT_UPDATE];

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            func_r     <= {7{`MPC_RST_FUNC}};
            mode_lo_r  <= `MPC_RST_MODE;
            mode_hi_r  <= `MPC_RST_MODE;
            strength_r <= `MPC_RST_STRENGTH;
        end else begin
            if (wr_func_w) begin
                func_r[func_idx_w] <= reg_wdata;
            end
            if (wr_mode_lo_w) begin
                mode_lo_r <= reg_wdata;
            end
            if (wr_mode_hi_w) begin
                mode_hi_r <= {2'b00, reg_wdata[5:0]};
            end
            if (wr_str_w) begin
                strength_r <= reg_wdata[6:0];
            end
        end
    end

    // ------------------------------------------------------------------------
    // Pending fields unpacked
    // ------------------------------------------------------------------------
    mpc_pins_t       pend_oe_w;
    logic [6:0][6:0] pend_code_w;
    logic [6:0][1:0] pend_mode_w;
    wire  [15:0]     pend_mode_flat_w = {mode_hi_r, mode_lo_r};

    always_comb begin
        for (int i = 0; i < 7; i++) begin
            pend_oe_w[i]   = func_r[i][`MPC_BIT_OE];
            pend_code_w[i] = func_r[i][6:0];
            pend_mode_w[i] = pend_mode_flat_w[2*i +: 2];
        end
    end

    // ------------------------------------------------------------------------
    // Active configuration, loaded only by an update
    // ------------------------------------------------------------------------
    mpc_pins_t       act_oe_r;
    logic [6:0][6:0] act_code_r;
    logic [6:0][1:0] act_mode_r;
    mpc_pins_t       act_weak_r;
    logic            freeze_r;
    logic            pin_upd_prev_r;

    // Frozen controls keep their last value; the pin-driven update itself is
    // frozen too, so only the register update can release a freeze.
    wire pin_upd_lvl_w  = ctrl_of(`MPC_CODE_UPDATE, pin_in, act_oe_r, act_code_r, act_mode_r);
    wire pin_upd_rise_w = pin_upd_lvl_w && !pin_upd_prev_r && !freeze_r && strap_done_w;
    wire upd_w          = wr_upd_w || pin_upd_rise_w;
    wire freeze_set_w   = wr_func_w && !act_oe_r[func_idx_w];

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            act_oe_r       <= '0;
            act_code_r     <= '0;
            act_mode_r     <= '0;
            act_weak_r     <= '0;
            freeze_r       <= 1'b0;
            pin_upd_prev_r <= 1'b0;
        end else begin
            pin_upd_prev_r <= freeze_r ? pin_upd_prev_r : pin_upd_lvl_w;
            if (upd_w) begin
                act_oe_r   <= pend_oe_w;
                act_code_r <= pend_code_w;
                act_mode_r <= pend_mode_w;
                act_weak_r <= strength_r;
            end
            // A new input-function write in the update cycle keeps the freeze.
            if (freeze_set_w) begin
                freeze_r <= 1'b1;
            end else if (upd_w) begin
                freeze_r <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------------------
    // Control destinations
    // ------------------------------------------------------------------------
    wire pd_w  = ctrl_of(`MPC_CODE_POWER_DOWN, pin_in, act_oe_r, act_code_r, act_mode_r);
    wire wd_w  = ctrl_of(`MPC_CODE_CLR_WDOG, pin_in, act_oe_r, act_code_r, act_mode_r);
    wire sy_w  = ctrl_of(`MPC_CODE_SYNC_ALL, pin_in, act_oe_r, act_code_r, act_mode_r);
    wire irq_w = ctrl_of(`MPC_CODE_CLR_IRQ, pin_in, act_oe_r, act_code_r, act_mode_r);

    // Controls stay low during the strap window, when the pins carry straps.
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            ctrl_power_down     <= 1'b0;
            ctrl_clear_watchdog <= 1'b0;
            ctrl_sync_all       <= 1'b0;
            ctrl_clear_irq      <= 1'b0;
            update_pulse        <= 1'b0;
        end else begin
            update_pulse <= upd_w;
            if (!freeze_r && strap_done_w) begin
                ctrl_power_down     <= pd_w;
                ctrl_clear_watchdog <= wd_w;
                ctrl_sync_all       <= sy_w;
                ctrl_clear_irq      <= irq_w;
            end
        end
    end

    // ------------------------------------------------------------------------
    // Pin output stage
    // ------------------------------------------------------------------------
    assign cfg.drive_allow = strap_done_w;
    assign cfg.ee_own      = eeprom_load_req;
    assign cfg.act_oe      = act_oe_r;
    assign cfg.act_code    = act_code_r;
    assign cfg.act_mode    = act_mode_r;
    assign cfg.act_weak    = act_weak_r;

    mpc_pin_driver u_drv (
        .clk_sys    (clk_sys),
        .rst_n      (rst_n),
        .cfg        (cfg),
        .status_src (status_src),
        .ee_active  (eeprom_active),
        .ee_a_oe    (eeprom_pin_a_oe),
        .ee_b_oe    (eeprom_pin_b_oe),
        .pin_out    (pin_out),
        .pin_oe     (pin_oe),
        .pin_weak   (pin_weak)
    );

    // ------------------------------------------------------------------------
    // Strap results
    // ------------------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            straps_done     <= 1'b0;
            eeprom_load_req <= 1'b0;
            port_is_i2c     <= 1'b0;
            i2c_dev_addr    <= `MPC_I2C_BASE;
        end else begin
            straps_done     <= strap_done_w;
            eeprom_load_req <= strap_load_w;
            port_is_i2c     <= strap_i2c_w;
            i2c_dev_addr    <= strap_addr_w;
        end
    end

    // ------------------------------------------------------------------------
    // Register read port
    // ------------------------------------------------------------------------
    wire rd_func_w  = (reg_addr >= `MPC_OFS_FUNC_FIRST) && (reg_addr <= `MPC_OFS_FUNC_LAST);
    wire [7:0] strap_stat_w = {straps_done, 3'b000, i2c_dev_addr[1:0], port_is_i2c, eeprom_load_req};
    wire [7:0] rd_mux_w =
        rd_func_w                              ? func_r[func_idx_w] :
        (reg_addr == `MPC_OFS_MODE_LO)         ? mode_lo_r :
        (reg_addr == `MPC_OFS_MODE_HI)         ? mode_hi_r :
        (reg_addr == `MPC_OFS_STRENGTH)        ? {1'b0, strength_r} :
        (reg_addr == `MPC_OFS_STRAP_STAT)      ? strap_stat_w :
                                                 8'h00;

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            reg_rdata  <= 8'h00;
            reg_rd_ack <= 1'b0;
        end else begin
            reg_rd_ack <= reg_rd_en;
            if (reg_rd_en) begin
                reg_rdata <= rd_mux_w;
            end
        end
    end
endmodule : mpc_multi_pin

// *** verilog/mpc_map.svh ***
// Register offsets, field positions, reset values and timing counts of the multifunction pin block.
`ifndef MPC_MAP_SVH
`define MPC_MAP_SVH
// ----------------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------------
`define MPC_OFS_UPDATE      16'h000F
`define MPC_OFS_MODE_LO     16'h0100
`define MPC_OFS_MODE_HI     16'h0101
`define MPC_OFS_FUNC_FIRST  16'h0102
`define MPC_OFS_FUNC_LAST   16'h0108
`define MPC_OFS_STRENGTH    16'h0109
`define MPC_OFS_STRAP_STAT  16'h010A
// ----------------------------------------------------------------------------
// Fields, codes and reset values
// ----------------------------------------------------------------------------
`define MPC_BIT_UPDATE      0
`define MPC_BIT_OE          7
`define MPC_PINS_IN_LO      4
`define MPC_RST_FUNC        8'h00
`define MPC_RST_MODE        8'h00
`define MPC_RST_STRENGTH    7'h00
`define MPC_I2C_BASE        7'h48
`define MPC_CODE_IDLE       7'h00
`define MPC_CODE_ONE        7'h01
`define MPC_CODE_UPDATE     7'h01
`define MPC_CODE_POWER_DOWN 7'h02
`define MPC_CODE_CLR_WDOG   7'h03
`define MPC_CODE_SYNC_ALL   7'h04
`define MPC_CODE_CLR_IRQ    7'h10
`define MPC_PIN_EE_A        1
`define MPC_PIN_EE_B        2
`define MPC_PIN_LOAD        3
`define MPC_PIN_PORT        4
`define MPC_PIN_ADDR_LO     5
`define MPC_PIN_ADDR_HI     6
// ----------------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------------
`define MPC_CLK_NS          10
`define MPC_STRAP_NS        100
`define MPC_STRAP_CYC       ((`MPC_STRAP_NS + `MPC_CLK_NS - 1) / `MPC_CLK_NS)
`endif

// *** verilog/mpc_pkg.sv ***
// Types shared by the multifunction pin block.
package mpc_pkg;
    typedef enum logic [1:0] {
        MPC_DRV_PP_HIGH = 2'b00,
        MPC_DRV_PP_LOW  = 2'b01,
        MPC_DRV_OD_HIGH = 2'b10,
        MPC_DRV_OD_LOW  = 2'b11
    } mpc_drive_e;
    typedef enum logic [1:0] {
        MPC_PH_RESET  = 2'b00,
        MPC_PH_SAMPLE = 2'b01,
        MPC_PH_RUN    = 2'b10
    } mpc_phase_e;
    typedef logic [6:0] mpc_pins_t;
endpackage : mpc_pkg

// *** verilog/mpc_cfg_if.sv ***
// Active pin configuration passed from the register core to the pin drivers.
`timescale 1ns/1ns
interface mpc_cfg_if;
    import mpc_pkg::*;
    logic            drive_allow;
    logic            ee_own;
    mpc_pins_t       act_oe;
    logic [6:0][6:0] act_code;
    logic [6:0][1:0] act_mode;
    mpc_pins_t       act_weak;
    modport src (output drive_allow, ee_own, act_oe, act_code, act_mode, act_weak);
    modport drv (input drive_allow, ee_own, act_oe, act_code, act_mode, act_weak);
endinterface : mpc_cfg_if

// *** verilog/mpc_strap_latch.sv ***
// Strap sampling window after reset release.
`timescale 1ns/1ns
`include "mpc_map.svh"
module mpc_strap_latch
    import mpc_pkg::*;
(
    input  wire logic       clk_sys,
    input  wire logic       rst_n,
    input  wire mpc_pins_t  pin_in,
    output logic            done,
    output logic            load_req,
    output logic            is_i2c,
    output logic [6:0]      i2c_addr
);
    mpc_phase_e phase_r;
    logic [7:0] cnt_r;
    wire        last_w = (cnt_r == 8'(`MPC_STRAP_CYC - 1));

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            phase_r  <= MPC_PH_RESET;
            cnt_r    <= 8'h00;
            done     <= 1'b0;
            load_req <= 1'b0;
            is_i2c   <= 1'b0;
            i2c_addr <= `MPC_I2C_BASE;
        end else begin
            case (phase_r)
                MPC_PH_RESET: begin
                    phase_r <= MPC_PH_SAMPLE;
                end
                MPC_PH_SAMPLE: begin
                    cnt_r <= cnt_r + 8'h01;
                    if (last_w) begin
                        phase_r  <= MPC_PH_RUN;
                        done     <= 1'b1;
                        load_req <= pin_in[`MPC_PIN_LOAD];
                        is_i2c   <= pin_in[`MPC_PIN_PORT];
                        i2c_addr <= `MPC_I2C_BASE | {5'h00, pin_in[`MPC_PIN_ADDR_HI], pin_in[`MPC_PIN_ADDR_LO]};
                    end
                end
                MPC_PH_RUN: begin
                    phase_r <= MPC_PH_RUN;
                end
                default: begin
                    phase_r <= MPC_PH_RESET;
                end
            endcase
        end
    end
endmodule : mpc_strap_latch

// *** verilog/mpc_pin_driver.sv ***
// Registered output stage of the seven multifunction pins.
`timescale 1ns/1ns
`include "mpc_map.svh"
module mpc_pin_driver
    import mpc_pkg::*;
(
    input  wire logic         clk_sys,
    input  wire logic         rst_n,
    mpc_cfg_if.drv            cfg,
    input  wire logic [127:0] status_src,
    input  wire logic         ee_active,
    input  wire logic         ee_a_oe,
    input  wire logic         ee_b_oe,
    output mpc_pins_t         pin_out,
    output mpc_pins_t         pin_oe,
    output mpc_pins_t         pin_weak
);
    mpc_pins_t out_nxt;
    mpc_pins_t oe_nxt;
    logic      asserted;

    always_comb begin
        out_nxt  = '0;
        oe_nxt   = '0;
        asserted = 1'b0;
        for (int i = 0; i < 7; i++) begin
            asserted = (cfg.act_code[i] == `MPC_CODE_IDLE) ? 1'b0 :
                       (cfg.act_code[i] == `MPC_CODE_ONE) ? 1'b1 : status_src[cfg.act_code[i]];
            case (mpc_drive_e'(cfg.act_mode[i]))
                MPC_DRV_PP_HIGH: begin out_nxt[i] = asserted;  oe_nxt[i] = 1'b1;     end
                MPC_DRV_PP_LOW:  begin out_nxt[i] = !asserted; oe_nxt[i] = 1'b1;     end
                MPC_DRV_OD_HIGH: begin out_nxt[i] = 1'b1;      oe_nxt[i] = asserted; end
                MPC_DRV_OD_LOW:  begin out_nxt[i] = 1'b0;      oe_nxt[i] = asserted; end
                default:         begin out_nxt[i] = 1'b0;      oe_nxt[i] = 1'b0;     end
            endcase
            oe_nxt[i] = oe_nxt[i] && cfg.act_oe[i] && cfg.drive_allow;
        end
        // The EEPROM master owns its two pins as open-drain lines while it runs.
        if (cfg.ee_own && ee_active) begin
            out_nxt[`MPC_PIN_EE_A] = 1'b0;
            oe_nxt[`MPC_PIN_EE_A]  = ee_a_oe;
            out_nxt[`MPC_PIN_EE_B] = 1'b0;
            oe_nxt[`MPC_PIN_EE_B]  = ee_b_oe;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            pin_out  <= '0;
            pin_oe   <= '0;
            pin_weak <= '0;
        end else begin
            pin_out  <= out_nxt;
            pin_oe   <= oe_nxt;
            pin_weak <= cfg.act_weak & cfg.act_oe;
        end
    end
endmodule : mpc_pin_driver

// *** sim/mpc_multi_pin_asserts.sv ***
// Concurrent checks on the top-level ports of the multifunction pin block.
`timescale 1ns/1ns
`include "mpc_map.svh"
module mpc_multi_pin_asserts
    import mpc_pkg::*;
(
    input  wire logic        clk_sys,
    input  wire logic        rst_n,
    input  wire logic        reg_wr_en,
    input  wire logic        reg_rd_en,
    input  wire logic [15:0] reg_addr,
    input  wire logic [7:0]  reg_wdata,
    input  wire logic [7:0]  reg_rdata,
    input  wire logic        reg_rd_ack,
    input  wire mpc_pins_t   pin_out,
    input  wire mpc_pins_t   pin_oe,
    input  wire mpc_pins_t   pin_weak,
    input  wire logic        eeprom_active,
    input  wire logic        eeprom_pin_a_oe,
    input  wire logic        eeprom_pin_b_oe,
    input  wire logic        straps_done,
    input  wire logic        eeprom_load_req,
    input  wire logic        port_is_i2c,
    input  wire logic [6:0]  i2c_dev_addr,
    input  wire logic        update_pulse
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    a_read_ack_once: assert property (reg_rd_ack == $past(reg_rd_en))
        else $error("read acknowledge does not follow the read strobe");
    a_update_reads_zero: assert property (reg_rd_en && reg_addr == `MPC_OFS_UPDATE |=> reg_rdata == 8'h00)
        else $error("update register did not read as zero");
    a_i2c_addr_base: assert property (i2c_dev_addr[6:2] == 5'h12)
        else $error("device address left its base range");
    a_straps_hold: assert property (straps_done && $past(straps_done) |->
        $stable({eeprom_load_req, port_is_i2c, i2c_dev_addr}))
        else $error("strap results changed after capture");
    a_reset_hiz: assert property (!straps_done |-> pin_oe == 7'h00)
        else $error("pin driven before straps were captured");
    a_update_pulse_soon: assert property (reg_wr_en && reg_addr == `MPC_OFS_UPDATE && reg_wdata[0]
        |-> ##[1:2] update_pulse)
        else $error("update write gave no update pulse");
    a_weak_on_update: assert property ($changed(pin_weak) |->
        update_pulse || $past(update_pulse) || $past(update_pulse, 2))
        else $error("drive strength changed without an update");
    a_eeprom_pin_own: assert property (eeprom_load_req && eeprom_active |=> pin_out[2:1] == 2'b00
        && pin_oe[2:1] == {$past(eeprom_pin_b_oe), $past(eeprom_pin_a_oe)})
        else $error("bus pins do not follow the loader");
endmodule : mpc_multi_pin_asserts

bind mpc_multi_pin mpc_multi_pin_asserts chk_u (.clk_sys, .rst_n, .reg_wr_en, .reg_rd_en, .reg_addr, .reg_wdata,
    .reg_rdata, .reg_rd_ack, .pin_out, .pin_oe, .pin_weak, .eeprom_active, .eeprom_pin_a_oe, .eeprom_pin_b_oe,
    .straps_done, .eeprom_load_req, .port_is_i2c, .i2c_dev_addr, .update_pulse);

// *** sim/mpc_board.sv ***
// Board-side model of the seven multifunction pins: external drivers and pull-down resistors.
`timescale 1ns/1ns
module mpc_board
    import mpc_pkg::*;
(
    input  wire mpc_pins_t pin_out,
    input  wire mpc_pins_t pin_oe,
    input  wire mpc_pins_t ext_lvl,
    input  wire mpc_pins_t ext_en,
    output mpc_pins_t      pin_in
);
    // External sources back off wherever the device drives, so the wire never sees contention.
    wire mpc_pins_t ext_on = ext_en & ~pin_oe;
    // An external source drives a firm level; undriven pins fall to the pull-down level.
    assign pin_in = (pin_oe & pin_out) | (ext_on & ext_lvl);
endmodule : mpc_board

// *** sim/mpc_multi_pin_tb.sv ***
// Self-checking testbench of the multifunction pin block.
`timescale 1ns/1ns
`include "mpc_map.svh"
`define TB_CHK(nm, exp, got) begin tests_run++; if ((got) !== (exp)) begin failures++; \
    $display("unexpected %s: expected %0h seen %0h", nm, exp, got); end end
module mpc_multi_pin_tb
    import mpc_pkg::*;
;
    logic         clk_sys = 0, rst_n = 0, reg_wr_en = 0, reg_rd_en = 0;
    logic [15:0]  reg_addr = '0;
    logic [7:0]   reg_wdata = '0, reg_rdata;
    logic         reg_rd_ack, straps_done, eeprom_load_req, port_is_i2c, update_pulse;
    logic [127:0] status_src = '0;
    logic         eeprom_active = 0, eeprom_pin_a_oe = 0, eeprom_pin_b_oe = 0;
    logic [6:0]   i2c_dev_addr;
    logic         ctrl_power_down, ctrl_clear_watchdog, ctrl_sync_all, ctrl_clear_irq;
    mpc_pins_t    pin_in, pin_out, pin_oe, pin_weak, ext_lvl = '0, ext_en = '0;
    int           failures = 0, tests_run = 0;

    mpc_multi_pin dut_u (.clk_sys, .rst_n, .reg_wr_en, .reg_rd_en, .reg_addr, .reg_wdata, .reg_rdata, .reg_rd_ack,
        .pin_in, .pin_out, .pin_oe, .pin_weak, .status_src, .eeprom_active, .eeprom_pin_a_oe, .eeprom_pin_b_oe,
        .straps_done, .eeprom_load_req, .port_is_i2c, .i2c_dev_addr, .update_pulse, .ctrl_power_down,
        .ctrl_clear_watchdog, .ctrl_sync_all, .ctrl_clear_irq);
    mpc_board brd_u (.pin_out, .pin_oe, .ext_lvl, .ext_en, .pin_in);

    initial begin
        forever #5 clk_sys = ~clk_sys;
    end
    // ----------------------------------------------------------------------------
    // Bus cycles and helpers
    // ----------------------------------------------------------------------------
    task automatic cyc(input int n);
        repeat (n) @(negedge clk_sys);
    endtask : cyc
    // The strobe is dropped for a cycle between writes so it is never assigned twice at one time.
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        reg_addr = a;
        reg_wdata = d;
        reg_wr_en = 1;
        cyc(1);
        reg_wr_en = 0;
        cyc(1);
    endtask : wr
    task automatic rd(input logic [15:0] a, input logic [7:0] exp);
        reg_addr = a;
        reg_rd_en = 1;
        cyc(1);
        reg_rd_en = 0;
        `TB_CHK("read ack", 1'b1, reg_rd_ack)
        `TB_CHK("read data", exp, reg_rdata)
        cyc(1);
    endtask : rd
    task automatic upd;
        wr(`MPC_OFS_UPDATE, 8'h01);
        cyc(2);
    endtask : upd
    task automatic stop_test;
        $display("comparisons %0d, mismatches %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : stop_test
    // ----------------------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------------------
    // Straps s = {addr_high, addr_low, port, load}; drv low leaves the pins to the pull-downs.
    task automatic t_straps(input logic [3:0] s, input logic drv);
        int n = 0;
        ext_en = drv ? 7'h78 : 7'h00;
        ext_lvl = {s, 3'b000};
        rst_n = 0;
        cyc(20);
        rst_n = 1;
        while (straps_done !== 1'b1 && n < 50) begin
            `TB_CHK("oe in strap window", 7'h00, pin_oe)
            cyc(1);
            n++;
        end
        if (straps_done !== 1'b1) begin
            `TB_CHK("straps done", 1'b1, straps_done)
            stop_test();
        end
        ext_lvl = ~ext_lvl;
        cyc(3);
        `TB_CHK("load request", s[0] & drv, eeprom_load_req)
        `TB_CHK("port select", s[1] & drv, port_is_i2c)
        `TB_CHK("device address", {5'h12, s[3:2] & {2{drv}}}, i2c_dev_addr)
        rd(`MPC_OFS_STRAP_STAT, {1'b1, 3'b000, s & {4{drv}}});
        $display("strap test done");
    endtask : t_straps
    task automatic t_eeprom;
        eeprom_active = 1;
        eeprom_pin_a_oe = 1;
        cyc(3);
        `TB_CHK("bus pins oe", 2'b01, pin_oe[2:1])
        `TB_CHK("bus pins out", 2'b00, pin_out[2:1])
        eeprom_active = 0;
        eeprom_pin_a_oe = 0;
        cyc(3);
        `TB_CHK("bus pins released", 2'b00, pin_oe[2:1])
        $display("loader test done");
    endtask : t_eeprom
    task automatic t_regs;
        for (int i = 0; i < 7; i++) rd(16'(`MPC_OFS_FUNC_FIRST + i), `MPC_RST_FUNC);
        for (int i = 0; i < 7; i++) wr(16'(`MPC_OFS_FUNC_FIRST + i), 8'(8'h80 | i));
        for (int i = 0; i < 7; i++) rd(16'(`MPC_OFS_FUNC_FIRST + i), 8'(8'h80 | i));
        for (int i = 0; i < 7; i++) wr(16'(`MPC_OFS_FUNC_FIRST + i), 8'h00);
        upd();
        `TB_CHK("unapplied outputs", 7'h00, pin_oe)
        wr(`MPC_OFS_MODE_HI, 8'hFF);
        rd(`MPC_OFS_MODE_HI, 8'h3F);
        wr(`MPC_OFS_MODE_HI, 8'h00);
        wr(`MPC_OFS_STRENGTH, 8'h7F);
        rd(`MPC_OFS_STRENGTH, 8'h7F);
        wr(`MPC_OFS_STRENGTH, 8'h00);
        rd(`MPC_OFS_UPDATE, 8'h00);
        rd(16'h0200, 8'h00);
        $display("register test done");
    endtask : t_regs
    task automatic t_status;
        status_src[5] = 1;
        wr(16'h0102, 8'h85);
        cyc(3);
        `TB_CHK("oe before update", 1'b0, pin_oe[0])
        upd();
        `TB_CHK("status drive", 2'b11, {pin_oe[0], pin_out[0]})
        wr(16'h0102, 8'h80);
        cyc(3);
        `TB_CHK("old function kept", 1'b1, pin_out[0])
        upd();
        `TB_CHK("new function", 1'b0, pin_out[0])
        wr(16'h0102, 8'h85);
        for (int m = 0; m < 4; m++) for (int a = 0; a < 2; a++) begin
            status_src[5] = a[0];
            wr(`MPC_OFS_MODE_LO, 8'(m));
            upd();
            `TB_CHK("drive mode", {m[1] ? a[0] : 1'b1, m[1] ? ~m[0] : a[0] ^ m[0]}, {pin_oe[0], pin_out[0]})
        end
        wr(`MPC_OFS_MODE_LO, 8'h00);
        wr(`MPC_OFS_STRENGTH, 8'h01);
        cyc(3);
        `TB_CHK("weak before update", 1'b0, pin_weak[0])
        upd();
        `TB_CHK("weak drive", 2'b11, {pin_oe[0], pin_weak[0]})
        wr(16'h0102, 8'h00);
        cyc(3);
        `TB_CHK("drive held", 1'b1, pin_oe[0])
        upd();
        `TB_CHK("pin released", 1'b0, pin_oe[0])
        wr(`MPC_OFS_STRENGTH, 8'h00);
        $display("status test done");
    endtask : t_status
    task automatic t_control;
        logic [6:0] code [4] = '{7'h02, 7'h03, 7'h04, 7'h10};
        ext_en = 7'h08;
        for (int k = 0; k < 4; k++) begin
            ext_lvl = 7'h00;
            wr(16'h0105, {1'b0, code[k]});
            upd();
            ext_lvl = 7'h08;
            cyc(3);
            `TB_CHK("control route", 4'(1 << k), {ctrl_clear_irq, ctrl_sync_all, ctrl_clear_watchdog, ctrl_power_down})
        end
        wr(16'h0105, 8'h02);
        ext_lvl = 7'h00;
        cyc(3);
        `TB_CHK("frozen controls", 4'h8, {ctrl_clear_irq, ctrl_sync_all, ctrl_clear_watchdog, ctrl_power_down})
        upd();
        `TB_CHK("resumed controls", 4'h0, {ctrl_clear_irq, ctrl_sync_all, ctrl_clear_watchdog, ctrl_power_down})
        ext_lvl = 7'h08;
        cyc(3);
        `TB_CHK("new control", 4'h1, {ctrl_clear_irq, ctrl_sync_all, ctrl_clear_watchdog, ctrl_power_down})
        ext_lvl = 7'h00;
        wr(16'h0105, 8'h01);
        upd();
        ext_lvl = 7'h08;
        cyc(1);
        `TB_CHK("pin update", 1'b1, update_pulse)
        $display("control test done");
    endtask : t_control

    initial begin
        t_straps(4'b0000, 1'b0);
        t_straps(4'b1010, 1'b1);
        t_straps(4'b0111, 1'b1);
        t_eeprom();
        t_regs();
        t_status();
        t_control();
        stop_test();
    end
endmodule : mpc_multi_pin_tb
